// >>> design/hri_pkg.sv
// Purpose: Constants and types for the handler result port block.
// Assumes: 32-bit Avalon-MM register bus, byte addressing, 50 MHz sys_clk.
// Notes: Flag index doubles as the operand code of the custom logic outputs.
//
// Function
// R1 - Each accepted trigger assertion starts exactly one measurement.
// R2 - Ready output goes high once the measurement has finished.
// R3 - End-of-test flag goes high when the conversion completes.
// R4 - Handler swaps the component only after end-of-test goes high.
// R5 - In binning, the matching bin line of eight goes high (pass).
// R6 - Out-of-bin line goes high when the result misses all eight bins.
// R7 - In compare, low output asserts when value is below lower limit.
// R8 - In compare, high output asserts when value exceeds upper limit.
// R9 - Fail output asserts when compare result is high or low.
// R10 - Pass output asserts when compare result is inside the limits.
// R11 - Result lines are active only with compare or binning selected.
// R12 - Port has seventeen logic outputs and one logic input.
// R13 - Each custom output shows its active level when its condition holds.
// R14 - Clear mode: results drop at end-of-test fall, new ones at its rise.
// R15 - Hold mode: previous results stay until the current test completes.
// R16 - Custom condition joins two operands by OR, AND, or OFF (first only).
// R17 - Each custom output has a selectable active level, high or low.
// R18 - Trigger is synchronised and acted on once per rising edge.
package hri_pkg;

  // Register byte offsets
  localparam logic [6:0] HRI_OFF_CTRL = 7'h00;
  localparam logic [6:0] HRI_OFF_UD1 = 7'h04;
  localparam logic [6:0] HRI_OFF_UD2 = 7'h08;
  localparam logic [6:0] HRI_OFF_STATUS = 7'h0C;
  localparam logic [6:0] HRI_OFF_CMPLO = 7'h10;
  localparam logic [6:0] HRI_OFF_CMPHI = 7'h14;
  localparam logic [6:0] HRI_OFF_VALUE = 7'h18;
  localparam logic [6:0] HRI_OFF_BIN = 7'h20;
  localparam logic [6:0] HRI_OFF_BINEND = 7'h60;

  // Control register fields
  localparam int HRI_CTRL_FUNC_LSB = 0;
  localparam int HRI_CTRL_HOLD_BIT = 4;
  localparam logic [1:0] HRI_FUNC_OFF = 2'h0;
  localparam logic [1:0] HRI_FUNC_CMP = 2'h1;
  localparam logic [1:0] HRI_FUNC_BIN = 2'h2;

  // Custom logic config fields
  localparam int HRI_UD_OP1_LSB = 0;
  localparam int HRI_UD_OP2_LSB = 4;
  localparam int HRI_UD_OPER_LSB = 8;
  localparam int HRI_UD_ACT_BIT = 12;
  localparam logic [1:0] HRI_OPER_OFF = 2'h0;
  localparam logic [1:0] HRI_OPER_OR = 2'h1;
  localparam logic [1:0] HRI_OPER_AND = 2'h2;

  // Status register fields
  localparam int HRI_ST_READY_BIT = 0;
  localparam int HRI_ST_ENDTEST_BIT = 1;
  localparam int HRI_ST_BUSY_BIT = 2;
  localparam int HRI_ST_FLAG_LSB = 8;

  // Result flag positions, also the operand codes
  localparam int HRI_NFLAG = 13;
  localparam int HRI_FLG_FAIL = 0;
  localparam int HRI_FLG_PASS = 1;
  localparam int HRI_FLG_LOW = 2;
  localparam int HRI_FLG_HIGH = 3;
  localparam int HRI_FLG_BOUT = 4;
  localparam int HRI_FLG_BIN0 = 5;
  localparam int HRI_NBIN = 8;

  // Reset values
  localparam logic [31:0] HRI_RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] HRI_RST_UD = 32'h0000_1000;
  localparam logic [31:0] HRI_RST_LIMIT = 32'h0000_0000;

  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_FINISH} hri_state_e;

endpackage : hri_pkg

// >>> design/hri_res_if.sv
// Purpose: Carries the raw result flags from the grader to the custom logic.
// Assumes: Flags are registered by the source.
// Notes: One source, any number of sinks.
`timescale 1ns/100ps
interface hri_res_if;
  import hri_pkg::*;
  logic [HRI_NFLAG-1:0] flags;
  logic active;

  modport src (output flags, output active);
  modport sink (input flags, input active);
endinterface : hri_res_if

// >>> design/hri_top.sv
// Purpose: Handler result port: trigger in, status and grading lines out.
// Assumes: Measurement core answers measStart with convDone, then measDone.
// Notes: Registers over Avalon-MM; every access takes one wait cycle.
`timescale 1ns/100ps
module hri_top
  import hri_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic handlerTrigger,
  output logic measStart,
  input wire logic convDone,
  input wire logic measDone,
  input wire logic [31:0] measValue,
  output logic handlerReady,
  output logic endOfTestFlag,
  output logic failOut,
  output logic passOut,
  output logic lowOut,
  output logic highOut,
  output logic [HRI_NBIN-1:0] binGradeOut,
  output logic outOfBinOut,
  output logic customLogicOut1,
  output logic customLogicOut2
);

  // Byte-enable merge for register writes
  function automatic logic [31:0] beMerge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction : beMerge

  // Configuration registers
  logic [31:0] ctrl_q;
  logic [31:0] ud1_q;
  logic [31:0] ud2_q;
  logic [31:0] cmpLo_q;
  logic [31:0] cmpHi_q;
  logic [31:0] binLo_q [HRI_NBIN];
  logic [31:0] binHi_q [HRI_NBIN];

  // Bus slave state
  logic ack_q;
  logic [31:0] rdData_q;
  logic req;
  logic wrEn;

  // Decode wires
  logic aligned;
  logic selCtrl;
  logic selUd1;
  logic selUd2;
  logic selStatus;
  logic selCmpLo;
  logic selCmpHi;
  logic selValue;
  logic selBin;
  logic [6:0] binOff;
  logic [2:0] binIdx;
  logic binIsHi;
  logic [31:0] rdMux;
  logic [31:0] statusWord;

  // Trigger path
  logic trigMeta_q;
  logic trigSync_q;
  logic trigPrev_q;
  logic trigRise;

  // Measurement sequence
  hri_state_e state_q;
  hri_state_e state_d;
  logic startMeas;
  logic measStart_q;
  logic ready_q;
  logic endOfTest_q;
  logic [31:0] value_q;

  // Grading
  logic [1:0] func;
  logic holdMode;
  logic cmpSel;
  logic binSel;
  logic gradeActive;
  logic isLow;
  logic isHigh;
  logic [HRI_NBIN-1:0] inBin;
  logic [HRI_NBIN-1:0] binFirst;
  logic [HRI_NFLAG-1:0] gradeNow;
  logic [HRI_NFLAG-1:0] flags_q;

  // Output registers
  logic failOut_q;
  logic passOut_q;
  logic lowOut_q;
  logic highOut_q;
  logic [HRI_NBIN-1:0] binOut_q;
  logic outOfBin_q;

  hri_res_if resBus ();

  // Address decode
  assign req = avs_read | avs_write;
  assign aligned = (avs_address[1:0] == 2'h0);
  assign selCtrl = aligned & (avs_address == HRI_OFF_CTRL);
  assign selUd1 = aligned & (avs_address == HRI_OFF_UD1);
  assign selUd2 = aligned & (avs_address == HRI_OFF_UD2);
  assign selStatus = aligned & (avs_address == HRI_OFF_STATUS);
  assign selCmpLo = aligned & (avs_address == HRI_OFF_CMPLO);
  assign selCmpHi = aligned & (avs_address == HRI_OFF_CMPHI);
  assign selValue = aligned & (avs_address == HRI_OFF_VALUE);
  assign selBin = aligned & (avs_address >= HRI_OFF_BIN) &
                  (avs_address < HRI_OFF_BINEND);
  assign binOff = avs_address - HRI_OFF_BIN;
  assign binIdx = binOff[5:3];
  assign binIsHi = binOff[2];

  // One wait cycle, then the access completes
  assign avs_waitrequest = req & ~ack_q;
  assign wrEn = avs_write & ack_q;
  assign avs_readdata = rdData_q;

  // Status word shows sequence and latched results
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[HRI_ST_READY_BIT] = ready_q;
    statusWord[HRI_ST_ENDTEST_BIT] = endOfTest_q;
    statusWord[HRI_ST_BUSY_BIT] = (state_q != ST_IDLE);
    statusWord[HRI_ST_FLAG_LSB +: HRI_NFLAG] = flags_q;
  end

  // Read selection, unmapped reads return zero
  assign rdMux = selCtrl ? ctrl_q :
                 selUd1 ? ud1_q :
                 selUd2 ? ud2_q :
                 selStatus ? statusWord :
                 selCmpLo ? cmpLo_q :
                 selCmpHi ? cmpHi_q :
                 selValue ? value_q :
                 selBin ? (binIsHi ? binHi_q[binIdx] : binLo_q[binIdx]) :
                 32'h0000_0000;

  // Bus handshake and read data
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdData_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (avs_read & ~ack_q) begin
        rdData_q <= rdMux;
      end
    end
  end

  // Writable registers, unmapped writes are dropped
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= HRI_RST_CTRL;
      ud1_q <= HRI_RST_UD;
      ud2_q <= HRI_RST_UD;
      cmpLo_q <= HRI_RST_LIMIT;
      cmpHi_q <= HRI_RST_LIMIT;
      for (int i = 0; i < HRI_NBIN; i++) begin
        binLo_q[i] <= HRI_RST_LIMIT;
        binHi_q[i] <= HRI_RST_LIMIT;
      end
    end else if (wrEn) begin
      if (selCtrl) ctrl_q <= beMerge(ctrl_q, avs_writedata, avs_byteenable);
      if (selUd1) ud1_q <= beMerge(ud1_q, avs_writedata, avs_byteenable);
      if (selUd2) ud2_q <= beMerge(ud2_q, avs_writedata, avs_byteenable);
      if (selCmpLo) cmpLo_q <= beMerge(cmpLo_q, avs_writedata, avs_byteenable);
      if (selCmpHi) cmpHi_q <= beMerge(cmpHi_q, avs_writedata, avs_byteenable);
      if (selBin & binIsHi) begin
        binHi_q[binIdx] <= beMerge(binHi_q[binIdx], avs_writedata,
                                   avs_byteenable);
      end
      if (selBin & ~binIsHi) begin
        binLo_q[binIdx] <= beMerge(binLo_q[binIdx], avs_writedata,
                                   avs_byteenable);
      end
    end
  end

  // Trigger synchroniser and edge detect on the settled stage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      trigMeta_q <= 1'b0;
      trigSync_q <= 1'b0;
      trigPrev_q <= 1'b0;
    end else begin
      trigMeta_q <= handlerTrigger; // R18
      trigSync_q <= trigMeta_q; // R18
      trigPrev_q <= trigSync_q;
    end
  end

  assign trigRise = trigSync_q & ~trigPrev_q; // R18

  // A trigger counts only while idle, so one edge gives one measurement
  assign startMeas = (state_q == ST_IDLE) & trigRise; // R1

  // Measurement sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (startMeas) state_d = ST_CONV; // R1
      end
      ST_CONV: begin
        if (convDone & measDone) state_d = ST_IDLE;
        else if (convDone) state_d = ST_FINISH;
      end
      ST_FINISH: begin
        if (measDone) state_d = ST_IDLE; // R2
      end
    endcase
  end

  // Control fields
  assign func = ctrl_q[HRI_CTRL_FUNC_LSB +: 2];
  assign holdMode = ctrl_q[HRI_CTRL_HOLD_BIT];
  assign cmpSel = (func == HRI_FUNC_CMP); // R11
  assign binSel = (func == HRI_FUNC_BIN); // R11
  assign gradeActive = cmpSel | binSel; // R11

  // Compare judgement on the converted value
  assign isLow = (measValue < cmpLo_q); // R7
  assign isHigh = (measValue > cmpHi_q); // R8

  // Bin range match, lowest matching bin wins
  always_comb begin
    binFirst = '0;
    for (int i = HRI_NBIN - 1; i >= 0; i--) begin
      inBin[i] = (measValue >= binLo_q[i]) & (measValue <= binHi_q[i]);
      if (inBin[i]) binFirst = 8'h01 << i;
    end
  end

  // Raw flags of the test that is completing now
  always_comb begin
    gradeNow = '0;
    gradeNow[HRI_FLG_LOW] = isLow; // R7
    gradeNow[HRI_FLG_HIGH] = isHigh; // R8
    gradeNow[HRI_FLG_FAIL] = isLow | isHigh; // R9
    gradeNow[HRI_FLG_PASS] = ~(isLow | isHigh); // R10
    gradeNow[HRI_FLG_BIN0 +: HRI_NBIN] = binFirst; // R5
    gradeNow[HRI_FLG_BOUT] = (inBin == 8'h00); // R6
  end

  // Sequence registers, end-of-test and result latch
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      measStart_q <= 1'b0;
      ready_q <= 1'b1;
      endOfTest_q <= 1'b1;
      value_q <= 32'h0000_0000;
      flags_q <= '0;
    end else begin
      state_q <= state_d;
      measStart_q <= startMeas; // R1
      if (startMeas) begin
        ready_q <= 1'b0;
        endOfTest_q <= 1'b0;
        if (!holdMode) flags_q <= '0; // R14
      end
      if ((state_q == ST_CONV) & convDone) begin
        endOfTest_q <= 1'b1; // R3
        value_q <= measValue;
        flags_q <= gradeNow; // R14 R15
      end
      if ((state_q != ST_IDLE) & (state_d == ST_IDLE)) begin
        ready_q <= 1'b1; // R2
      end
    end
  end

  // Pin registers gated by the selected function
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      failOut_q <= 1'b0;
      passOut_q <= 1'b0;
      lowOut_q <= 1'b0;
      highOut_q <= 1'b0;
      binOut_q <= '0;
      outOfBin_q <= 1'b0;
    end else begin
      failOut_q <= cmpSel & flags_q[HRI_FLG_FAIL]; // R9 R11
      passOut_q <= cmpSel & flags_q[HRI_FLG_PASS]; // R10 R11
      lowOut_q <= cmpSel & flags_q[HRI_FLG_LOW]; // R7 R11
      highOut_q <= cmpSel & flags_q[HRI_FLG_HIGH]; // R8 R11
      binOut_q <= {HRI_NBIN{binSel}} & flags_q[HRI_FLG_BIN0 +: HRI_NBIN]; // R5
      outOfBin_q <= binSel & flags_q[HRI_FLG_BOUT]; // R6 R11
    end
  end

  // Flags shared with the custom logic outputs
  assign resBus.flags = flags_q;
  assign resBus.active = gradeActive;

  hri_user_logic userLogic1 (
    .sys_clk(sys_clk),
    .rst(rst),
    .cfg(ud1_q),
    .res(resBus),
    .pinOut(customLogicOut1)
  );

  hri_user_logic userLogic2 (
    .sys_clk(sys_clk),
    .rst(rst),
    .cfg(ud2_q),
    .res(resBus),
    .pinOut(customLogicOut2)
  );

  // Fifteen handler outputs plus the core start strobe
  assign measStart = measStart_q;
  assign handlerReady = ready_q; // R12
  assign endOfTestFlag = endOfTest_q; // R12 R4
  assign failOut = failOut_q;
  assign passOut = passOut_q;
  assign lowOut = lowOut_q;
  assign highOut = highOut_q;
  assign binGradeOut = binOut_q;
  assign outOfBinOut = outOfBin_q;

endmodule : hri_top

// >>> design/hri_user_logic.sv
// Purpose: One custom logic output built from two result operands.
// Assumes: Config is static between tests; flags come registered.
// Notes: Operand codes above the last flag read as false.
`timescale 1ns/100ps
module hri_user_logic
  import hri_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [31:0] cfg,
  hri_res_if.sink res,
  output logic pinOut
);

  logic [3:0] op1;
  logic [3:0] op2;
  logic [1:0] oper;
  logic activeHigh;
  logic val1;
  logic val2;
  logic condTrue;
  logic pinOut_q;
  logic pinOut_d;

  // Field split of the config word
  assign op1 = cfg[HRI_UD_OP1_LSB +: 4];
  assign op2 = cfg[HRI_UD_OP2_LSB +: 4];
  assign oper = cfg[HRI_UD_OPER_LSB +: 2];
  assign activeHigh = cfg[HRI_UD_ACT_BIT];

  // Operand selection from the result flags
  assign val1 = (int'(op1) < HRI_NFLAG) ? res.flags[op1] : 1'b0; // R16
  assign val2 = (int'(op2) < HRI_NFLAG) ? res.flags[op2] : 1'b0; // R16

  // Operator, unused code behaves as OFF
  assign condTrue = (oper == HRI_OPER_OR) ? (val1 | val2) :
                    (oper == HRI_OPER_AND) ? (val1 & val2) :
                    val1; // R16

  // Active level applied while a grading function is selected
  assign pinOut_d = (res.active & condTrue) ? activeHigh : ~activeHigh; // R13 R17

  // Output register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pinOut_q <= 1'b0;
    end else begin
      pinOut_q <= pinOut_d;
    end
  end

  assign pinOut = pinOut_q;

endmodule : hri_user_logic

// >>> tb/hri_handler_model.sv
// Purpose: Handler and measurement core stand-in around the result port.
// Assumes: go is held until measStart is seen.
// Notes: Value lines toggle outside the convDone cycle.
`timescale 1ns/100ps
module hri_handler_model #(
  parameter int CONV = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [31:0] value,
  input wire logic measStart,
  input wire logic endOfTestFlag,
  input wire logic handlerReady,
  output logic handlerTrigger = 1'b0,
  output logic convDone = 1'b0,
  output logic measDone = 1'b0,
  output logic [31:0] measValue = 32'h0,
  output logic busy
);
  int cnt = 0;

  assign busy = handlerTrigger || cnt != 0;

  // Trigger, conversion and finish sequencing
  always @(posedge sys_clk) begin
    convDone <= 1'b0;
    measDone <= 1'b0;
    measValue <= ~measValue;
    if (rst) begin
      cnt <= 0;
      handlerTrigger <= 1'b0;
    end else begin
      if (go && handlerReady && cnt == 0) handlerTrigger <= 1'b1;
      if (measStart) cnt <= 1;
      else if (cnt != 0) cnt <= cnt + 1;
      if (cnt == CONV) begin
        convDone <= 1'b1;
        measValue <= value;
      end
      if (cnt > CONV && endOfTestFlag) handlerTrigger <= 1'b0;
      if (cnt == CONV + 2) begin
        measDone <= 1'b1;
        cnt <= 0;
      end
    end
  end
endmodule : hri_handler_model

// >>> tb/hri_top_asserts.sv
// Purpose: Timing and grading relations at the handler result port.
// Assumes: Trigger rises only while the port is idle.
// Notes: Bound to hri_top; sees its ports only.
`timescale 1ns/100ps
module hri_top_asserts
  import hri_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic handlerTrigger,
  input wire logic measStart,
  input wire logic convDone,
  input wire logic measDone,
  input wire logic handlerReady,
  input wire logic endOfTestFlag,
  input wire logic failOut,
  input wire logic passOut,
  input wire logic lowOut,
  input wire logic highOut,
  input wire logic [HRI_NBIN-1:0] binGradeOut,
  input wire logic outOfBinOut
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Start sequence after a synchronised trigger edge
  AST_START: assert property ($rose(handlerTrigger) && handlerReady |-> ##3 measStart)
    else $error("trigger did not start a measurement");
  AST_ONE_PULSE: assert property (measStart |=> (!measStart && !handlerReady) [*2])
    else $error("start pulse repeated or ready early");
  AST_EOT_LOW: assert property (measStart |-> !endOfTestFlag && !handlerReady)
    else $error("end of test not low at start");
  AST_EOT_RISE: assert property (convDone && !endOfTestFlag |=> endOfTestFlag)
    else $error("end of test late after conversion");
  AST_READY: assert property (measDone && !handlerReady |=> handlerReady)
    else $error("ready late after finish");

  // Grading line relations
  AST_FAIL: assert property (failOut == (lowOut || highOut))
    else $error("fail line disagrees with low or high");
  AST_PASS: assert property (passOut |-> !lowOut && !highOut)
    else $error("pass together with low or high");
  AST_BIN: assert property ($onehot0({binGradeOut, outOfBinOut}))
    else $error("more than one bin line high");
  AST_FUNC: assert property ((passOut || failOut) |-> !outOfBinOut && binGradeOut == '0)
    else $error("compare and bin lines both active");
endmodule : hri_top_asserts

bind hri_top hri_top_asserts hri_top_asserts_inst (.sys_clk, .rst,
  .handlerTrigger, .measStart, .convDone, .measDone, .handlerReady,
  .endOfTestFlag, .failOut, .passOut, .lowOut, .highOut, .binGradeOut,
  .outOfBinOut);

// >>> tb/hri_top_bench.sv
// Purpose: Drives registers and measurements, compares every result line.
// Assumes: Register bus answers after one wait cycle.
// Notes: Expected lines are rebuilt from limits, bins and custom configs.
`timescale 1ns/100ps
module hri_top_bench;
  import hri_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [6:0] avs_address = 7'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, measValue, rdq, lo, hi, ud1, ud2;
  logic avs_waitrequest, handlerTrigger, measStart, convDone, measDone;
  logic handlerReady, endOfTestFlag, failOut, passOut, lowOut, highOut;
  logic outOfBinOut, customLogicOut1, customLogicOut2, busy;
  logic go = 1'b0;
  logic [31:0] value = 32'h0;
  logic [HRI_NBIN-1:0] binGradeOut;
  logic [1:0] func;
  logic [31:0] blo [HRI_NBIN];
  logic [31:0] bhi [HRI_NBIN];
  logic [14:0] pins, prev;
  logic [31:0] cmpv [5] = '{32'h63, 32'h64, 32'hC8, 32'hC9, 32'h96};
  logic [31:0] binv [6] = '{32'h64, 32'h91, 32'hC8, 32'h1AD, 32'h1AE, 32'h63};
  int errors = 0;
  int comparisons = 0;
  int starts = 0;

  // Clock and start counter
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (measStart) starts <= starts + 1;
  assign pins = {customLogicOut2, customLogicOut1, binGradeOut, outOfBinOut,
    highOut, lowOut, passOut, failOut};

  hri_top hri_top_inst (.sys_clk(sys_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .handlerTrigger(handlerTrigger), .measStart(measStart),
    .convDone(convDone), .measDone(measDone), .measValue(measValue),
    .handlerReady(handlerReady), .endOfTestFlag(endOfTestFlag),
    .failOut(failOut), .passOut(passOut), .lowOut(lowOut),
    .highOut(highOut), .binGradeOut(binGradeOut), .outOfBinOut(outOfBinOut),
    .customLogicOut1(customLogicOut1), .customLogicOut2(customLogicOut2));

  hri_handler_model hri_handler_model_inst (.sys_clk(sys_clk), .rst(rst),
    .go(go), .value(value), .measStart(measStart),
    .endOfTestFlag(endOfTestFlag), .handlerReady(handlerReady),
    .handlerTrigger(handlerTrigger), .convDone(convDone),
    .measDone(measDone), .measValue(measValue), .busy(busy));

  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic conclude;
    $display("Comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  // One register access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [6:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  function automatic logic cust(input logic [31:0] c, input logic [12:0] f);
    logic a, b, t;
    a = c[3:0] < 4'hD ? f[c[3:0]] : 1'b0;
    b = c[7:4] < 4'hD ? f[c[7:4]] : 1'b0;
    t = c[9:8] == HRI_OPER_OR ? a | b : c[9:8] == HRI_OPER_AND ? a & b : a;
    return t ~^ c[12];
  endfunction : cust

  function automatic logic [14:0] expect_pins(input logic [31:0] v,
                                              input logic clr);
    logic [12:0] f;
    logic [14:0] r;
    int k;
    f = '0;
    k = -1;
    if (!clr) begin
      f[HRI_FLG_LOW] = v < lo;
      f[HRI_FLG_HIGH] = v > hi;
      f[HRI_FLG_PASS] = !(v < lo) && !(v > hi);
      f[HRI_FLG_FAIL] = (v < lo) || (v > hi);
      for (int i = HRI_NBIN - 1; i >= 0; i--)
        if (v >= blo[i] && v <= bhi[i]) k = i;
      if (k >= 0) f[HRI_FLG_BIN0 + k] = 1'b1;
      f[HRI_FLG_BOUT] = k < 0;
    end
    r = {cust(ud2, f), cust(ud1, f), 13'h0};
    if (func == HRI_FUNC_CMP) r[3:0] = f[3:0];
    else if (func == HRI_FUNC_BIN) r[12:4] = f[12:4];
    else r[14:13] = {!ud2[12], !ud1[12]};
    return r;
  endfunction : expect_pins

  task automatic setup(input logic [31:0] ctrl);
    func = ctrl[1:0];
    bus(1'b1, HRI_OFF_CTRL, ctrl, rdq);
    bus(1'b1, HRI_OFF_UD1, ud1, rdq);
    bus(1'b1, HRI_OFF_UD2, ud2, rdq);
    bus(1'b1, HRI_OFF_CMPLO, lo, rdq);
    bus(1'b1, HRI_OFF_CMPHI, hi, rdq);
    for (int i = 0; i < HRI_NBIN; i++) begin
      bus(1'b1, HRI_OFF_BIN + 7'(8 * i), blo[i], rdq);
      bus(1'b1, HRI_OFF_BIN + 7'(8 * i + 4), bhi[i], rdq);
    end
    bus(1'b0, HRI_OFF_UD2, 32'h0, rdq);
    chk("ud2Readback", rdq, ud2);
  endtask : setup

  // One handler cycle; mode 0 expects cleared lines mid-test, 1 held ones
  task automatic meas(input logic [31:0] v, input int mode);
    int s0;
    s0 = starts;
    @(posedge sys_clk);
    value <= v;
    go <= 1'b1;
    do @(posedge sys_clk); while (measStart !== 1'b1);
    go <= 1'b0;
    repeat (2) @(posedge sys_clk);
    if (mode == 0) chk("clearedLines", pins, expect_pins(v, 1'b1));
    if (mode == 1) chk("heldLines", pins, prev);
    do @(posedge sys_clk); while (busy !== 1'b0 || handlerReady !== 1'b1);
    repeat (2) @(posedge sys_clk);
    prev = expect_pins(v, 1'b0);
    chk("resultLines", pins, prev);
    chk("startCount", starts - s0, 1);
  endtask : meas

  // Watchdog
  initial begin
    repeat (6000) @(posedge sys_clk);
    errors++;
    conclude();
  end

  // Main sequence
  initial begin
    for (int i = 0; i < HRI_NBIN; i++) begin
      blo[i] = 32'h64 + 32'(40 * i);
      bhi[i] = 32'h95 + 32'(40 * i);
    end
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk("resetLines", pins, 15'h0);
    bus(1'b0, HRI_OFF_CTRL, 32'h0, rdq);
    chk("ctrlReset", rdq, HRI_RST_CTRL);
    bus(1'b0, HRI_OFF_UD1, 32'h0, rdq);
    chk("udReset", rdq, HRI_RST_UD);
    bus(1'b0, HRI_OFF_STATUS, 32'h0, rdq);
    chk("statusReset", rdq[2:0], 3'h3);
    bus(1'b1, 7'h7C, 32'hFFFF_FFFF, rdq);
    bus(1'b0, 7'h7C, 32'h0, rdq);
    chk("unmapped", rdq, 32'h0);
    $display("register test done");
    lo = 32'h64;
    hi = 32'hC8;
    ud1 = 32'h1001;
    ud2 = 32'h0203;
    setup(32'h01);
    foreach (cmpv[i]) meas(cmpv[i], 0);
    $display("compare test done");
    ud1 = 32'h1147;
    ud2 = 32'h000C;
    setup(32'h12);
    meas(32'h63, 2);
    foreach (binv[i]) meas(binv[i], 1);
    $display("binning test done");
    setup(32'h00);
    meas(32'h96, 0);
    bus(1'b0, HRI_OFF_VALUE, 32'h0, rdq);
    chk("lastValue", rdq, 32'h96);
    $display("inactive function test done");
    conclude();
  end
endmodule : hri_top_bench
